// ---- mmdec_pkg.sv ----
// package: address map constants and region codes for the memory map decoder
`default_nettype none
package mmdec_pkg;
    // ***************************************************************
    // address map
    // ***************************************************************
    localparam logic [15:0] SFB_LO = 16'h0000;
    localparam logic [15:0] SFB_HI = 16'h000F;
    localparam logic [15:0] BPER_LO = 16'h0010;
    localparam logic [15:0] BPER_HI = 16'h00FF;
    localparam logic [15:0] WPER_LO = 16'h0100;
    localparam logic [15:0] WPER_HI = 16'h01FF;
    localparam logic [15:0] MEM_LO = 16'h0200;
    localparam logic [15:0] MEM_HI = 16'hFFFF;
    localparam logic [15:0] VEC_TOP = 16'hFFFE;
    localparam int VEC_WORDS = 16;
    localparam logic [15:0] VEC_LO = 16'hFFE0;
    // default implemented bounds: rom lowest address, ram highest address
    localparam logic [15:0] ROM_LO_DEF = 16'hF000;
    localparam logic [15:0] RAM_HI_DEF = 16'h09FF;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // ***************************************************************
    // region selects
    // ***************************************************************
    typedef enum logic [2:0] {
        MMDEC_REG_NONE = 3'h0,
        MMDEC_REG_SFB = 3'h1,
        MMDEC_REG_BPER = 3'h2,
        MMDEC_REG_WPER = 3'h3,
        MMDEC_REG_RAM = 3'h4,
        MMDEC_REG_ROM = 3'h5
    } mmdec_region_t;
endpackage
`default_nettype wire

// ---- mmdec_lane.sv ----
// lane steering: write data to byte lanes and read merge per region
`timescale 1ns/10ps
`default_nettype none
module mmdec_lane (
    // access
    input wire logic [15:0] addr,
    input wire logic byte_op,
    input wire logic [15:0] wdata,
    input wire mmdec_pkg::mmdec_region_t region,
    // memory side
    output logic [15:0] mem_wdata,
    output logic [1:0] mem_be,
    // read merge
    input wire logic [15:0] rd_raw,
    output logic [15:0] rd_data
);
    // ***************************************************************
    // write side
    // ***************************************************************
    // byte writes copy the low byte to both lanes; odd address picks high lane,
    // except byte modules: they only ever see the low lane, whatever the address
    always_comb begin
        if (byte_op) begin
            mem_wdata = {wdata[7:0], wdata[7:0]};
            if (region == mmdec_pkg::MMDEC_REG_SFB || region == mmdec_pkg::MMDEC_REG_BPER) begin
                mem_be = 2'h1;
            end else begin
                mem_be = addr[0] ? 2'h2 : 2'h1;
            end
        end else begin
            mem_wdata = wdata;
            mem_be = 2'h3;
        end
    end

    // ***************************************************************
    // read side
    // ***************************************************************
    always_comb begin
        case (region)
            // byte modules sit on the low lanes only; high byte dropped
            mmdec_pkg::MMDEC_REG_SFB,
            mmdec_pkg::MMDEC_REG_BPER: begin
                rd_data = {8'h00, rd_raw[7:0]};
            end
            mmdec_pkg::MMDEC_REG_WPER: begin
                rd_data = byte_op ? {8'h00, rd_raw[7:0]} : rd_raw;
            end
            mmdec_pkg::MMDEC_REG_RAM,
            mmdec_pkg::MMDEC_REG_ROM: begin
                if (!byte_op) begin
                    rd_data = rd_raw;
                end else if (addr[0]) begin
                    rd_data = {8'h00, rd_raw[15:8]};
                end else begin
                    rd_data = {8'h00, rd_raw[7:0]};
                end
            end
            default: begin
                rd_data = mmdec_pkg::ZERO_WORD;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- mmdec_top.sv ----
// memory map decoder: region select, strobes and registered read return
`timescale 1ns/10ps
`default_nettype none
// Operation
// - rom, ram, registers and peripherals share one 64KB space
// - word modules and memory get 16-bit lanes, byte modules only 8-bit lanes
// - program and data memory take byte and word reads and writes
// - word low byte at even address, high byte at next odd
// - 0 to 01FFh peripherals, 0200h to 0FFFFh memory
// - vector table is top 16 rom words, highest at 0FFFEh
// - rom lower bound set by size, rom ends at top
// - 0h to 0Fh selects the special function bytes
// - 010h to 0FFh selects byte peripherals on 8-bit lanes
// - 100h to 01FFh selects word peripherals on 16-bit lanes
// - instruction fetches allowed from ram and rom
// - byte peripheral writes keep low byte; word read high byte undefined
// - byte access to word peripheral: even only, high result zero
module mmdec_top #(
    parameter logic [15:0] ROM_LO = mmdec_pkg::ROM_LO_DEF,
    parameter logic [15:0] RAM_HI = mmdec_pkg::RAM_HI_DEF
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // processor request
    input wire logic req,
    input wire logic we,
    input wire logic byte_op,
    input wire logic fetch,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    // processor answer
    output logic [15:0] rdata,
    output logic rvalid,
    output logic vec_hit,
    output logic size_err,
    // memory_data_bus towards modules
    output logic [15:0] mdb_addr,
    output logic [15:0] memory_data_bus_wdata,
    output logic [1:0] mdb_be,
    output logic mdb_we,
    output logic sel_sfb,
    output logic sel_bper,
    output logic sel_wper,
    output logic sel_ram,
    output logic sel_rom,
    // read returns from modules
    input wire logic [7:0] sfb_rdata,
    input wire logic [7:0] bper_rdata,
    input wire logic [15:0] wper_rdata,
    input wire logic [15:0] ram_rdata,
    input wire logic [15:0] rom_rdata
);
    // ***************************************************************
    // decode
    // ***************************************************************
    // range test, used for every region
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    mmdec_pkg::mmdec_region_t region;
    mmdec_pkg::mmdec_region_t region_q;
    logic byte_q;
    logic [15:0] addr_q;
    logic [15:0] rd_raw;
    logic [15:0] rd_merged;
    logic [15:0] lane_wdata;
    logic [1:0] lane_be;
    logic bad_size;

    // priority chain gives at most one select per access; addresses in no region select none
    always_comb begin
        if (in_range(addr, mmdec_pkg::SFB_LO, mmdec_pkg::SFB_HI)) begin
            region = mmdec_pkg::MMDEC_REG_SFB;
        end else if (in_range(addr, mmdec_pkg::BPER_LO, mmdec_pkg::BPER_HI)) begin
            region = mmdec_pkg::MMDEC_REG_BPER;
        end else if (in_range(addr, mmdec_pkg::WPER_LO, mmdec_pkg::WPER_HI)) begin
            region = mmdec_pkg::MMDEC_REG_WPER;
        end else if (in_range(addr, ROM_LO, mmdec_pkg::MEM_HI)) begin
            region = mmdec_pkg::MMDEC_REG_ROM;
        end else if (in_range(addr, mmdec_pkg::MEM_LO, RAM_HI)) begin
            region = mmdec_pkg::MMDEC_REG_RAM;
        end else begin
            region = mmdec_pkg::MMDEC_REG_NONE;
        end
    end

    // flag master slips rather than trusting them: word to byte module,
    // odd word, odd fetch, odd byte into word module
    always_comb begin
        bad_size = 1'b0;
        if (!byte_op && addr[0]) begin
            bad_size = 1'b1;
        end
        if (fetch && addr[0]) begin
            bad_size = 1'b1;
        end
        if (!byte_op && (region == mmdec_pkg::MMDEC_REG_SFB ||
                         region == mmdec_pkg::MMDEC_REG_BPER)) begin
            bad_size = 1'b1;
        end
        if (byte_op && addr[0] && region == mmdec_pkg::MMDEC_REG_WPER) begin
            bad_size = 1'b1;
        end
    end

    // ***************************************************************
    // lane steering
    // ***************************************************************
    mmdec_lane u_lane (
        .addr(addr_q),
        .byte_op(byte_q),
        .wdata(wdata),
        .region(region_q),
        .mem_wdata(),
        .mem_be(),
        .rd_raw(rd_raw),
        .rd_data(rd_merged)
    );

    // write-path steering uses the live request
    mmdec_lane u_wlane (
        .addr(addr),
        .byte_op(byte_op),
        .wdata(wdata),
        .region(region),
        .mem_wdata(lane_wdata),
        .mem_be(lane_be),
        .rd_raw(mmdec_pkg::ZERO_WORD),
        .rd_data()
    );

    // pick the return of the region selected last cycle
    always_comb begin
        case (region_q)
            mmdec_pkg::MMDEC_REG_SFB: rd_raw = {8'h00, sfb_rdata};
            mmdec_pkg::MMDEC_REG_BPER: rd_raw = {8'h00, bper_rdata};
            mmdec_pkg::MMDEC_REG_WPER: rd_raw = wper_rdata;
            mmdec_pkg::MMDEC_REG_RAM: rd_raw = ram_rdata;
            mmdec_pkg::MMDEC_REG_ROM: rd_raw = rom_rdata;
            default: rd_raw = mmdec_pkg::ZERO_WORD;
        endcase
    end

    // ***************************************************************
    // registered strobes toward modules
    // ***************************************************************
    // one cycle of latency buys flop-driven outputs for timing closure
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mdb_addr <= 16'h0000;
            memory_data_bus_wdata <= 16'h0000;
            mdb_be <= 2'h0;
            mdb_we <= 1'b0;
            sel_sfb <= 1'b0;
            sel_bper <= 1'b0;
            sel_wper <= 1'b0;
            sel_ram <= 1'b0;
            sel_rom <= 1'b0;
        end else begin
            mdb_addr <= addr;
            memory_data_bus_wdata <= lane_wdata;
            mdb_be <= req ? lane_be : 2'h0;
            mdb_we <= req && we;
            sel_sfb <= req && region == mmdec_pkg::MMDEC_REG_SFB;
            sel_bper <= req && region == mmdec_pkg::MMDEC_REG_BPER;
            sel_wper <= req && region == mmdec_pkg::MMDEC_REG_WPER;
            sel_ram <= req && region == mmdec_pkg::MMDEC_REG_RAM;
            sel_rom <= req && region == mmdec_pkg::MMDEC_REG_ROM;
        end
    end

    // ***************************************************************
    // request capture and answer
    // ***************************************************************
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            region_q <= mmdec_pkg::MMDEC_REG_NONE;
            byte_q <= 1'b0;
            addr_q <= 16'h0000;
            vec_hit <= 1'b0;
            size_err <= 1'b0;
        end else begin
            region_q <= req ? region : mmdec_pkg::MMDEC_REG_NONE;
            byte_q <= byte_op;
            addr_q <= addr;
            // vectors are the top words of rom, 0FFFEh highest
            vec_hit <= req && !we && in_range(addr, mmdec_pkg::VEC_LO,
                                              mmdec_pkg::MEM_HI);
            size_err <= req && bad_size;
        end
    end

    // read data arrives one cycle after the strobe
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rvalid <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            rvalid <= sel_sfb | sel_bper | sel_wper | sel_ram | sel_rom
                      | (region_q == mmdec_pkg::MMDEC_REG_NONE && mdb_be != 2'h0);
            rdata <= mdb_we ? mmdec_pkg::ZERO_WORD : rd_merged;
        end
    end
endmodule
`default_nettype wire

// ---- mmdec_checker.sv ----
// checker: decode, lane and answer timing of the memory map decoder
`timescale 1ns/10ps
`default_nettype none
module mmdec_checker #(
    parameter logic [15:0] ROM_LO = mmdec_pkg::ROM_LO_DEF
) (
    // clock, reset and request
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic req,
    input wire logic we,
    input wire logic byte_op,
    input wire logic [15:0] addr,
    // answer and strobes
    input wire logic rvalid,
    input wire logic vec_hit,
    input wire logic [15:0] mdb_addr,
    input wire logic [1:0] mdb_be,
    input wire logic sel_sfb,
    input wire logic sel_bper,
    input wire logic sel_wper,
    input wire logic sel_ram,
    input wire logic sel_rom
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ***************************************************************
    // region decode, one cycle after the request
    // ***************************************************************
    property p_sfb; req && addr <= 16'h000F |=> sel_sfb; endproperty
    a_sfb: assert property (p_sfb) else $error("sfb select missing");
    property p_bper; req && addr[15:8] == 8'h00 && addr[7:4] != 4'h0 |=> sel_bper; endproperty
    a_bper: assert property (p_bper) else $error("byte module select missing");
    property p_wper; req && addr[15:9] == 7'h00 && addr[8] |=> sel_wper; endproperty
    a_wper: assert property (p_wper) else $error("word module select missing");
    property p_mem; req && addr >= 16'h0200 |=> !(sel_sfb || sel_bper || sel_wper); endproperty
    a_mem: assert property (p_mem) else $error("memory address hit a module");
    property p_rom; req && addr >= ROM_LO |=> sel_rom; endproperty
    a_rom: assert property (p_rom) else $error("rom select missing");
    property p_one; $onehot0({sel_sfb, sel_bper, sel_wper, sel_ram, sel_rom}); endproperty
    a_one: assert property (p_one) else $error("more than one select");
    // ***************************************************************
    // answer timing, vectors and word lanes
    // ***************************************************************
    property p_rv; req |-> ##2 rvalid; endproperty
    a_rv: assert property (p_rv) else $error("answer not two cycles on");
    property p_vec; req && !we && addr >= 16'hFFE0 |=> vec_hit; endproperty
    a_vec: assert property (p_vec) else $error("vector read not flagged");
    property p_word; req && !byte_op |=> mdb_be == 2'h3 && mdb_addr == $past(addr); endproperty
    a_word: assert property (p_word) else $error("word lanes wrong");
endmodule
bind mmdec_top mmdec_checker #(.ROM_LO(ROM_LO)) u_chk (.ref_clk, .reset, .req, .we,
    .byte_op, .addr, .rvalid, .vec_hit, .mdb_addr, .mdb_be, .sel_sfb, .sel_bper,
    .sel_wper, .sel_ram, .sel_rom);
`default_nettype wire

// ---- mmdec_cpu_model.sv ----
// processor core model issuing byte and word accesses
`timescale 1ns/10ps
`default_nettype none
module mmdec_cpu_model (
    // clock
    input wire logic ref_clk,
    // request
    output logic req,
    output logic we,
    output logic byte_op,
    output logic fetch,
    output logic [15:0] addr,
    output logic [15:0] wdata
);
    // quiet bus from time zero
    initial begin
        {req, we, byte_op, fetch, addr, wdata} = 36'h0;
    end
    // size, alignment and fetch parity stay legal unless a test asks otherwise
    task automatic xfer(input logic w, b, f, input logic [15:0] a, d);
        {req, we, byte_op, fetch, addr, wdata} <= {1'b1, w, b, f, a, d};
        @(posedge ref_clk);
    endtask
    // released lines move, so a stale address cannot look valid
    task automatic idle();
        {req, addr, wdata} <= {1'b0, ~addr, ~wdata};
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ---- tb_memory_map_decoder.sv ----
// testbench: decoder map, lanes, sizes, vectors and pipelining
`timescale 1ns/10ps
`default_nettype none
module tb_memory_map_decoder;
    logic ref_clk, reset, req, we, byte_op, fetch, rvalid, vec_hit, size_err, mdb_we, got_rv;
    logic got_we;
    logic [15:0] addr, wdata, rdata, mdb_addr, mdb_wd, wper_rd, ram_rd, rom_rd, base;
    logic [15:0] got_wd, got_rd;
    logic [7:0] sfb_rd, bper_rd;
    // one net, five output pins driving separate bits
    wire [4:0] sel;
    logic [4:0] got_sel;
    logic [1:0] mdb_be, got_be, got_flg;
    int num_errors = 0;
    int checked = 0;
    // module returns, combinational from the strobed address
    assign base = {mdb_addr[15:1], 1'b0};
    assign sfb_rd = base[7:0] ^ 8'hC3;
    assign bper_rd = base[7:0] ^ 8'h3C;
    assign wper_rd = base ^ 16'h0FF0;
    assign ram_rd = base ^ 16'hA55A;
    assign rom_rd = base ^ 16'h5AA5;
    mmdec_cpu_model u_cpu (.ref_clk(ref_clk), .req(req), .we(we), .byte_op(byte_op),
        .fetch(fetch), .addr(addr), .wdata(wdata));
    mmdec_top #(.ROM_LO(16'hE000), .RAM_HI(16'h09FF)) u_dut (.ref_clk(ref_clk), .reset(reset),
        .req(req), .we(we), .byte_op(byte_op), .fetch(fetch), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid), .vec_hit(vec_hit), .size_err(size_err),
        .mdb_addr(mdb_addr), .memory_data_bus_wdata(mdb_wd), .mdb_be(mdb_be), .mdb_we(mdb_we),
        .sel_sfb(sel[4]), .sel_bper(sel[3]), .sel_wper(sel[2]), .sel_ram(sel[1]),
        .sel_rom(sel[0]), .sfb_rdata(sfb_rd), .bper_rdata(bper_rd), .wper_rdata(wper_rd),
        .ram_rdata(ram_rd), .rom_rdata(rom_rd));
    // expected read: byte modules and byte reads leave the upper half zero
    function automatic logic [15:0] exp_rd(input logic [4:0] s, input logic [15:0] a,
        input logic b);
        logic [15:0] w;
        w = {a[15:1], 1'b0};
        case (s)
            5'h10: return {8'h00, w[7:0] ^ 8'hC3};
            5'h08: return {8'h00, w[7:0] ^ 8'h3C};
            5'h04: w = w ^ 16'h0FF0;
            5'h02: w = w ^ 16'hA55A;
            5'h01: w = w ^ 16'h5AA5;
            default: return 16'h0000;
        endcase
        if (!b) return w;
        return a[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one access; strobes read one edge on, answer the edge after
    task automatic acc(input logic w, b, f, input logic [15:0] a, d);
        @(posedge ref_clk);
        u_cpu.xfer(w, b, f, a, d);
        u_cpu.idle();
        got_sel = sel;
        got_we = mdb_we;
        got_be = mdb_be;
        got_wd = mdb_wd;
        got_flg = {vec_hit, size_err};
        @(posedge ref_clk);
        got_rd = rdata;
        got_rv = rvalid;
    endtask
    task automatic probe(input logic b, f, input logic [15:0] a, input logic [4:0] es,
        input logic [1:0] ef);
        acc(1'b0, b, f, a, 16'h0000);
        chk({got_rv, got_we, 9'h000, got_sel}, {1'b1, 1'b0, 9'h000, es});
        chk({14'h0000, got_flg}, {14'h0000, ef});
        if (!ef[0]) chk(got_rd, exp_rd(es, a, b));
    endtask
    task automatic t_map();
        logic [15:0] at [10] = '{16'h000F, 16'h0010, 16'h00FF, 16'h0100, 16'h01FE,
            16'h0200, 16'h09FE, 16'h0A00, 16'hDFFE, 16'hE000};
        logic [4:0] st [10] = '{5'h10, 5'h08, 5'h08, 5'h04, 5'h04,
            5'h02, 5'h02, 5'h00, 5'h00, 5'h01};
        for (int i = 0; i < 10; i++) probe(st[i][4] | st[i][3], 1'b0, at[i], st[i], 2'h0);
        $display("map boundaries done");
    endtask
    task automatic t_lanes();
        logic [15:0] at [3] = '{16'h0300, 16'h0301, 16'h0021};
        logic [15:0] dt [3] = '{16'hBEEF, 16'h00AB, 16'h77CD};
        logic [15:0] wt [3] = '{16'hBEEF, 16'hABAB, 16'hCDCD};
        logic [1:0] bt [3] = '{2'h3, 2'h2, 2'h1};
        logic [4:0] st [3] = '{5'h02, 5'h02, 5'h08};
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, i > 0, 1'b0, at[i], dt[i]);
            chk(got_wd, wt[i]);
            chk({14'h0000, got_be}, {14'h0000, bt[i]});
            chk({got_rv, got_we, 9'h000, got_sel}, {2'h3, 9'h000, st[i]});
            chk(got_rd, 16'h0000);
        end
        $display("write lanes done");
    endtask
    task automatic t_size();
        probe(1'b1, 1'b0, 16'h0205, 5'h02, 2'h0);
        probe(1'b1, 1'b0, 16'h0102, 5'h04, 2'h0);
        probe(1'b1, 1'b0, 16'h0103, 5'h04, 2'h1);
        probe(1'b0, 1'b0, 16'h0020, 5'h08, 2'h1);
        probe(1'b0, 1'b1, 16'h0400, 5'h02, 2'h0);
        probe(1'b0, 1'b1, 16'h0401, 5'h02, 2'h1);
        probe(1'b0, 1'b0, 16'h0207, 5'h02, 2'h1);
        probe(1'b0, 1'b0, 16'hFFFE, 5'h01, 2'h2);
        probe(1'b1, 1'b0, 16'hFFE1, 5'h01, 2'h2);
        probe(1'b0, 1'b0, 16'hFFDE, 5'h01, 2'h0);
        $display("sizes and vectors done");
    endtask
    task automatic t_b2b();
        @(posedge ref_clk);
        u_cpu.xfer(1'b0, 1'b0, 1'b0, 16'h0204, 16'h0000);
        u_cpu.xfer(1'b0, 1'b1, 1'b0, 16'h0011, 16'h0000);
        chk({11'h000, sel}, 16'h0002);
        u_cpu.idle();
        chk({11'h000, sel}, 16'h0008);
        chk(rdata, exp_rd(5'h02, 16'h0204, 1'b0));
        @(posedge ref_clk);
        chk(rdata, exp_rd(5'h08, 16'h0011, 1'b1));
        $display("back to back done");
    endtask
    // reset lands on a live vector read: everything clears, next access is clean
    task automatic t_rst();
        @(posedge ref_clk);
        u_cpu.xfer(1'b0, 1'b0, 1'b0, 16'hFFFE, 16'h0000);
        reset <= 1'b1;
        u_cpu.idle();
        chk({rvalid, vec_hit, size_err, mdb_we, 7'h00, sel}, 16'h0000);
        chk(rdata, 16'h0000);
        reset <= 1'b0;
        probe(1'b0, 1'b0, 16'hFFFE, 5'h01, 2'h2);
        $display("mid-run reset done");
    endtask
    task automatic summarize();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // watchdog far beyond the roughly 112 cycles the tests need
    initial begin
        #20000;
        num_errors++;
        summarize();
    end
    // reset, then the tests in turn
    initial begin
        reset = 1'b1;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        t_map();
        t_lanes();
        t_size();
        t_b2b();
        t_rst();
        summarize();
    end
endmodule
`default_nettype wire
